/* common/rrset_consts.vh */
// Constants for the rotate-right and set-all-ones execution block.
// Assumes a 32-bit APB register bus with 8-bit byte addresses.
`ifndef RRSET_CONSTS_VH
`define RRSET_CONSTS_VH

// Register byte offsets.
`define RRSET_OFF_CTRL    8'h00
`define RRSET_OFF_INSTR   8'h04
`define RRSET_OFF_BANK    8'h08
`define RRSET_OFF_WREG    8'h0C
`define RRSET_OFF_STATUS  8'h10
`define RRSET_OFF_INDEX   8'h14
`define RRSET_OFF_FADDR   8'h18
`define RRSET_OFF_FDATA   8'h1C

// Field positions.
`define RRSET_CTRL_EXT    0
`define RRSET_ST_ZERO     0
`define RRSET_ST_NEG      1
`define RRSET_ST_BUSY     2
`define RRSET_ST_ILLEGAL  3
`define RRSET_INSTR_D     9
`define RRSET_INSTR_A     8

// Instruction opcode patterns.
`define RRSET_OPC_RRNC    6'b01_0000
`define RRSET_OPC_SET     7'b011_0100

// Addressing and result constants.
`define RRSET_INDEX_LIMIT 8'h5F
`define RRSET_ACCESS_SPLIT 8'h60
`define RRSET_ACCESS_HIGH 4'hF
`define RRSET_ALL_ONES    8'hFF

// Reset values.
`define RRSET_RST_BYTE    8'h00
`define RRSET_RST_WORD    32'h0000_0000
`define RRSET_RST_INSTR   16'h0000
`define RRSET_RST_ADDR    12'h000

// Quarter-cycle states.
`define RRSET_Q1          2'b00
`define RRSET_Q2          2'b01
`define RRSET_Q3          2'b10
`define RRSET_Q4          2'b11

`endif

/* logic/rrset_exec.v */
// Execution of the rotate-right-no-carry and set-all-ones byte instructions.
// Assumes an APB master on the same clock; the file memory lives here.
`timescale 1ns/1ps
`include "rrset_consts.vh"

module rrset_exec (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);

  localparam ADDR_W = 12;

  // Quarter-cycle states of one instruction cycle.
  localparam [1:0] QTR_DECODE  = `RRSET_Q1;
  localparam [1:0] QTR_READ    = `RRSET_Q2;
  localparam [1:0] QTR_PROCESS = `RRSET_Q3;
  localparam [1:0] QTR_WRITE   = `RRSET_Q4;

  reg  [7:0]        file_mem [0:(1<<ADDR_W)-1];
  reg               ext_enable;
  reg  [15:0]       instr;
  reg  [3:0]        bank_select_reg;
  reg  [7:0]        wreg;
  reg               flag_zero;
  reg               flag_neg;
  reg               illegal;
  reg  [ADDR_W-1:0] index_base;
  reg  [ADDR_W-1:0] faddr;
  reg               busy;
  reg  [1:0]        quarter;
  reg  [ADDR_W-1:0] eff_addr;
  reg  [7:0]        operand;
  reg  [7:0]        result;
  reg               op_rotate;
  reg  [31:0]       rd_value;

  wire              access   = psel & penable;
  wire              fire     = access & pready;
  wire              wr_fire  = fire & pwrite;
  wire              is_rrnc  = (instr[15:10] == `RRSET_OPC_RRNC);
  wire              is_set   = (instr[15:9] == `RRSET_OPC_SET);
  wire              dest_w   = is_rrnc & ~instr[`RRSET_INSTR_D];
  wire              in_q4    = busy & (quarter == QTR_WRITE);
  wire              file_wr  = in_q4 & ~(op_rotate & dest_w);
  wire              fd_write = wr_fire & ~busy & (paddr == `RRSET_OFF_FDATA);

  // Forms the file address from the access bit, bank and indexed mode.
  function [ADDR_W-1:0] rrset_addr;
    input             a;
    input [7:0]       f;
    input [3:0]       bank;
    input             ext;
    input [ADDR_W-1:0] base;
    begin
      if (!a && ext && (f <= `RRSET_INDEX_LIMIT)) begin
        rrset_addr = base + {4'h0, f};
      end else if (!a) begin
        rrset_addr = (f < `RRSET_ACCESS_SPLIT) ? {4'h0, f}
                                               : {`RRSET_ACCESS_HIGH, f};
      end else begin
        rrset_addr = {bank, f};
      end
    end
  endfunction

  // Decodes an aligned register offset.
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[1:0] == 2'b00) && (addr[7:5] == 3'b000);
    end
  endfunction

  always @* begin
    rd_value = `RRSET_RST_WORD;
    case (paddr)
      `RRSET_OFF_CTRL:   rd_value[`RRSET_CTRL_EXT] = ext_enable;
      `RRSET_OFF_INSTR:  rd_value[15:0] = instr;
      `RRSET_OFF_BANK:   rd_value[3:0] = bank_select_reg;
      `RRSET_OFF_WREG:   rd_value[7:0] = wreg;
      `RRSET_OFF_STATUS: begin
        rd_value[`RRSET_ST_ZERO]    = flag_zero;
        rd_value[`RRSET_ST_NEG]     = flag_neg;
        rd_value[`RRSET_ST_BUSY]    = busy;
        rd_value[`RRSET_ST_ILLEGAL] = illegal;
      end
      `RRSET_OFF_INDEX:  rd_value[ADDR_W-1:0] = index_base;
      `RRSET_OFF_FADDR:  rd_value[ADDR_W-1:0] = faddr;
      `RRSET_OFF_FDATA:  rd_value[7:0] = file_mem[faddr];
      default:           rd_value = `RRSET_RST_WORD;
    endcase
  end

  // Each access phase lasts two cycles; the answer is taken on the second.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RRSET_RST_WORD;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped(paddr);
      prdata  <= (access & ~pready & ~pwrite) ? rd_value : `RRSET_RST_WORD;
    end
  end

  // Software registers; hardware updates take priority in the same cycle.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_enable      <= 1'b0;
      bank_select_reg <= 4'h0;
      index_base      <= `RRSET_RST_ADDR;
      faddr           <= `RRSET_RST_ADDR;
      wreg            <= `RRSET_RST_BYTE;
      flag_zero       <= 1'b0;
      flag_neg        <= 1'b0;
      illegal         <= 1'b0;
    end else begin
      if (wr_fire && !busy) begin
        case (paddr)
          `RRSET_OFF_CTRL:  ext_enable <= pwdata[`RRSET_CTRL_EXT];
          `RRSET_OFF_BANK:  bank_select_reg <= pwdata[3:0];
          `RRSET_OFF_INDEX: index_base <= pwdata[ADDR_W-1:0];
          `RRSET_OFF_FADDR: faddr <= pwdata[ADDR_W-1:0];
          `RRSET_OFF_WREG:  wreg <= pwdata[7:0];
          `RRSET_OFF_STATUS: begin
            flag_zero <= pwdata[`RRSET_ST_ZERO];
            flag_neg  <= pwdata[`RRSET_ST_NEG];
            if (pwdata[`RRSET_ST_ILLEGAL]) begin
              illegal <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      if (busy && quarter == QTR_DECODE && !is_rrnc && !is_set) begin
        illegal <= 1'b1;
      end
      if (in_q4 && op_rotate) begin
        flag_zero <= (result == `RRSET_RST_BYTE);
        flag_neg  <= result[7];
        if (dest_w) begin
          wreg <= result;
        end
      end
    end
  end

  // Quarter-cycle sequencer: decode, read file, process, write destination.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy      <= 1'b0;
      quarter   <= QTR_DECODE;
      instr     <= `RRSET_RST_INSTR;
      eff_addr  <= `RRSET_RST_ADDR;
      operand   <= `RRSET_RST_BYTE;
      result    <= `RRSET_RST_BYTE;
      op_rotate <= 1'b0;
    end else if (!busy) begin
      quarter <= QTR_DECODE;
      if (wr_fire && paddr == `RRSET_OFF_INSTR) begin
        instr <= pwdata[15:0];
        busy  <= 1'b1;
      end
    end else begin
      case (quarter)
        QTR_DECODE: begin
          eff_addr  <= rrset_addr(instr[`RRSET_INSTR_A], instr[7:0],
                                  bank_select_reg, ext_enable, index_base);
          op_rotate <= is_rrnc;
          if (is_rrnc || is_set) begin
            quarter <= QTR_READ;
          end else begin
            busy <= 1'b0;
          end
        end
        QTR_READ: begin
          operand <= file_mem[eff_addr];
          quarter <= QTR_PROCESS;
        end
        QTR_PROCESS: begin
          result  <= op_rotate ? {operand[0], operand[7:1]}
                               : `RRSET_ALL_ONES;
          quarter <= QTR_WRITE;
        end
        QTR_WRITE: begin
          busy    <= 1'b0;
          quarter <= QTR_DECODE;
        end
        default: quarter <= QTR_DECODE;
      endcase
    end
  end

  // File memory has no reset; the write port serves Q4 and software.
  always @(posedge clock) begin
    if (file_wr) begin
      file_mem[eff_addr] <= result;
    end else if (fd_write) begin
      file_mem[faddr] <= pwdata[7:0];
    end
  end

endmodule // rrset_exec

/* test/rrset_exec_properties.sv */
// Concurrent checks on the register bus ports of the execution block.
// Assumes one clock domain and a master that holds each request until pready.
`timescale 1ns/1ps
module rrset_props (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_answer; psel && penable && !pready |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_in_access; pready |-> psel && penable && $past(psel && penable); endproperty
  a_in_access: assert property (p_in_access) else $error("pready outside access");
  property p_err_rdy; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
  property p_idle; !pready |-> prdata == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("prdata not zero");
  property p_unal; pready && paddr[1:0] != 2'b00 |-> pslverr; endproperty
  a_unal: assert property (p_unal) else $error("unaligned accepted");
  property p_range; pready && paddr > 8'h1C |-> pslverr; endproperty
  a_range: assert property (p_range) else $error("unmapped accepted");
  property p_mapped; pready && paddr[1:0] == 2'b00 && paddr <= 8'h1C |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped refused");
endmodule // rrset_props
bind rrset_exec rrset_props chk_u (.clock(clock), .rst_n(rst_n), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* test/rrset_exec_test.sv */
// Self-checking bench for the rotate and set-all-ones execution block.
// Assumes the block is reached only through its APB slave port.
`timescale 1ns/1ps
module rrset_exec_test;
  logic        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  int          fail_count = 0, n_tests = 0;
  rrset_exec dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  initial forever #4 clock = ~clock;
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    i = 0;
    do begin @(posedge clock); i++; end while (pready !== 1'b1 && i < 20);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    // One idle edge keeps a following setup from reassigning psel in this step.
    @(posedge clock);
    if (i >= 20) begin fail_count++; stop_test; end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0); chk(nm, rd, e);
  endtask
  task run(input logic [15:0] ins);
    int i;
    wr(8'h04, {16'h0000, ins}); i = 0;
    do begin apb(0, 8'h10, 0); i++; end while (rd[2] !== 1'b0 && i < 10);
    if (i >= 10) begin fail_count++; stop_test; end
  endtask
  task fset(input logic [11:0] a, input logic [7:0] v); wr(8'h18, a); wr(8'h1C, v); endtask
  task fchk(input logic [11:0] a, input logic [7:0] v); wr(8'h18, a); rc("file", 8'h1C, v); endtask
  task t_reset;
    for (int a = 0; a < 8'h1C; a += 4) rc("reset", a[7:0], 32'h0000_0000);
    $display("reset done");
  endtask
  task t_rotate;
    wr(8'h08, 3); fset(12'h345, 8'hD7); run(16'h4345);
    fchk(12'h345, 8'hEB);
    rc("flags", 8'h10, 2);
    run(16'h4145);
    rc("wreg", 8'h0C, 8'hF5);
    fchk(12'h345, 8'hEB);
    fset(12'h345, 8'h00); run(16'h4345);
    rc("zero", 8'h10, 1);
    $display("rotate done");
  endtask
  task t_access;
    fset(12'h020, 8'h02); run(16'h4220);
    fchk(12'h020, 8'h01);
    fset(12'hF80, 8'h80); run(16'h4280);
    fchk(12'hF80, 8'h40);
    wr(8'h00, 1); wr(8'h14, 12'h200);
    fset(12'h210, 8'h04); run(16'h4210);
    fchk(12'h210, 8'h02);
    fset(12'h25F, 8'h08); run(16'h425F);
    fchk(12'h25F, 8'h04);
    fset(12'hF60, 8'h10); run(16'h4260);
    fchk(12'hF60, 8'h08);
    run(16'h6810);
    fchk(12'h210, 8'hFF);
    wr(8'h00, 0);
    $display("access done");
  endtask
  task t_set;
    wr(8'h08, 5); fset(12'h5AB, 8'h5A); wr(8'h10, 1); run(16'h69AB);
    fchk(12'h5AB, 8'hFF);
    rc("flags", 8'h10, 1);
    rc("wreg", 8'h0C, 8'hF5);
    fset(12'h030, 8'h00); run(16'h6830);
    fchk(12'h030, 8'hFF);
    run(16'h4030);
    rc("wreg", 8'h0C, 8'hFF);
    $display("set done");
  endtask
  task t_bus;
    apb(0, 8'h20, 0); chk("err", er, 1);
    apb(1, 8'h02, 1); chk("err", er, 1);
    run(16'hF000); chk("bad op", rd & 8, 8);
    wr(8'h10, 8); rc("clear", 8'h10, 0);
    $display("bus done");
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    t_reset; t_rotate; t_access; t_set; t_bus;
    stop_test;
  end
endmodule // rrset_exec_test
